// ### core/bms_params.svh
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

// Clock period of ref_clk_in, in picoseconds
`define BMS_CLK_PERIOD_PS 5000
// Least settle time of the strap pins after reset release
`define BMS_SETTLE_TIME_NS 100
`define BMS_SETTLE_CYCLES \
  ((`BMS_SETTLE_TIME_NS * 1000 + `BMS_CLK_PERIOD_PS - 1) / `BMS_CLK_PERIOD_PS)
// Longest wait for the flash image check
`define BMS_FLASH_WAIT_US 10
`define BMS_FLASH_WAIT_CYCLES ((`BMS_FLASH_WAIT_US * 1000000) / `BMS_CLK_PERIOD_PS)
// Pins set aside for entry into programming mode
`define BMS_MAX_ISP_PINS 4
`define BMS_STRAP_PINS 2

`endif

// ### core/bms_pkg.sv
package bms_pkg;

  // Selected boot mode, one-hot; zero means not yet decided
  typedef enum logic [3:0] {
    BMS_MODE_NONE  = 4'h0,
    BMS_MODE_FLASH = 4'h1,
    BMS_MODE_UART  = 4'h2,
    BMS_MODE_CAN   = 4'h4,
    BMS_MODE_USB   = 4'h8
  } bms_mode_t;

  // Boot sequencer states
  typedef enum logic [2:0] {
    BMS_ST_WAIT  = 3'h1,
    BMS_ST_CHECK = 3'h2,
    BMS_ST_DONE  = 3'h4
  } bms_state_t;

endpackage

// ### core/bms_strap_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bms_strap_if;
  logic strap_a;
  logic strap_b;
  logic valid;
  modport src (output strap_a, output strap_b, output valid);
  modport dst (input strap_a, input strap_b, input valid);
endinterface

`default_nettype wire

// ### core/bms_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"

module bms_strap_latch
  import bms_pkg::*;
#(
  parameter int SETTLE_CYCLES = `BMS_SETTLE_CYCLES
)(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic boot_strap_a_in,
  input wire logic boot_strap_b_in,
  bms_strap_if.src straps
);

  logic [15:0] cnt_q, cnt_d;
  logic valid_q, valid_d;
  logic a_q, a_d;
  logic b_q, b_d;

  // Wait out the settle time, then capture once; later strap moves are ignored
  always_comb
  begin
    cnt_d = cnt_q;
    valid_d = valid_q;
    a_d = a_q;
    b_d = b_q;
    if (!valid_q)
    begin
      if (cnt_q == 16'(SETTLE_CYCLES - 1))
      begin
        valid_d = 1'b1;
        a_d = boot_strap_a_in;
        b_d = boot_strap_b_in;
      end
      else
      begin
        cnt_d = cnt_q + 16'h1;
      end
    end
  end

  // Registers; reset loads constants only, straps are caught after release
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      cnt_q <= 16'h0;
      valid_q <= 1'b0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      valid_q <= valid_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  assign straps.strap_a = a_q;
  assign straps.strap_b = b_q;
  assign straps.valid = valid_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  chk_latch_hold: assert property (valid_q |=> valid_q && $stable(a_q) && $stable(b_q))
    else $error("strap latch changed after capture");

endmodule

`default_nettype wire

// ### core/boot_mode_strap_selector.sv
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"

module boot_mode_strap_selector
  import bms_pkg::*;
#(
  parameter int SETTLE_CYCLES = `BMS_SETTLE_CYCLES,
  parameter int FLASH_WAIT_CYCLES = `BMS_FLASH_WAIT_CYCLES
)(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic boot_strap_a_in,
  input wire logic boot_strap_b_in,
  input wire logic flash_check_done_in,
  input wire logic flash_valid_in,
  input wire logic serial_tx_data_in,
  input wire logic serial_rx_line_in,
  input wire logic can_tx_data_in,
  input wire logic can_rx_line_in,
  output logic [3:0] boot_mode_out,
  output logic boot_done_out,
  output logic flash_check_req_out,
  output logic flash_run_out,
  output logic serial_tx_line_out,
  output logic serial_tx_line_oe_out,
  output logic serial_rx_data_out,
  output logic can_tx_line_out,
  output logic can_tx_line_oe_out,
  output logic can_rx_data_out,
  output logic bus_power_sense_out,
  output logic [2:0] pins_reserved_out
);

  bms_strap_if straps ();

  // Strap capture after reset release
  bms_strap_latch #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_latch (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .boot_strap_a_in(boot_strap_a_in),
    .boot_strap_b_in(boot_strap_b_in),
    .straps(straps)
  );

  // Strap decode; a=1,b=1 is taken as flash boot so that a=1,b=0 can select CAN
  function automatic bms_mode_t strap_mode(input logic a, input logic b);
    bms_mode_t m;
    m = BMS_MODE_UART;
    if (a && b)
      m = BMS_MODE_FLASH;
    else if (a && !b)
      m = BMS_MODE_CAN;
    else if (!a && b)
      m = BMS_MODE_USB;
    else
      m = BMS_MODE_UART;
    return m;
  endfunction

  // Pins that a mode holds, the two straps included; the USB sense pin is strap b
  function automatic logic [2:0] mode_pins(input bms_mode_t m);
    logic [2:0] n;
    n = 3'h0;
    if (m == BMS_MODE_UART || m == BMS_MODE_CAN)
      n = 3'h2;
    return 3'(`BMS_STRAP_PINS) + n;
  endfunction

  bms_state_t state_q, state_d;
  bms_mode_t mode_q, mode_d;
  logic [15:0] wait_q, wait_d;

  // Boot sequencer: decide once, check flash if asked, then hold
  always_comb
  begin
    state_d = state_q;
    mode_d = mode_q;
    wait_d = wait_q;
    case (state_q)
      BMS_ST_WAIT:
      begin
        if (straps.valid)
        begin
          mode_d = strap_mode(straps.strap_a, straps.strap_b);
          wait_d = 16'h0;
          if (straps.strap_a && straps.strap_b)
            state_d = BMS_ST_CHECK;
          else
            state_d = BMS_ST_DONE;
        end
      end
      BMS_ST_CHECK:
      begin
        wait_d = wait_q + 16'h1;
        // A check that never answers is treated as an invalid image
        if (flash_check_done_in && flash_valid_in)
          state_d = BMS_ST_DONE;
        else if (flash_check_done_in || wait_q == 16'(FLASH_WAIT_CYCLES - 1))
        begin
          mode_d = BMS_MODE_USB;
          state_d = BMS_ST_DONE;
        end
      end
      BMS_ST_DONE:
      begin
        state_d = BMS_ST_DONE;
      end
      default:
      begin
        state_d = BMS_ST_WAIT;
        mode_d = BMS_MODE_NONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      state_q <= BMS_ST_WAIT;
      mode_q <= BMS_MODE_NONE;
      wait_q <= 16'h0;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      wait_q <= wait_d;
    end
  end

  // Registered pin outputs; an unclaimed line is not driven and its input ignored
  logic [3:0] mode_out_d;
  logic done_d, chk_req_d, run_d;
  logic stx_d, stx_oe_d, srx_d, ctx_d, ctx_oe_d, crx_d, vbus_d;
  logic [2:0] pins_d;
  logic is_done;

  always_comb
  begin
    is_done = (state_q == BMS_ST_DONE);
    mode_out_d = is_done ? mode_q : BMS_MODE_NONE;
    done_d = is_done;
    chk_req_d = (state_q == BMS_ST_CHECK);
    run_d = is_done && (mode_q == BMS_MODE_FLASH);
    stx_oe_d = is_done && (mode_q == BMS_MODE_UART);
    stx_d = stx_oe_d ? serial_tx_data_in : 1'b0;
    srx_d = (is_done && mode_q == BMS_MODE_UART) ? serial_rx_line_in : 1'b1;
    ctx_oe_d = is_done && (mode_q == BMS_MODE_CAN);
    ctx_d = ctx_oe_d ? can_tx_data_in : 1'b0;
    crx_d = (is_done && mode_q == BMS_MODE_CAN) ? can_rx_line_in : 1'b1;
    // Sense read live from the strap b pin, which doubles as bus power
    vbus_d = is_done && (mode_q == BMS_MODE_USB) && boot_strap_b_in;
    pins_d = (is_done && mode_q != BMS_MODE_FLASH) ? mode_pins(mode_q) : 3'h0;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      boot_mode_out <= BMS_MODE_NONE;
      boot_done_out <= 1'b0;
      flash_check_req_out <= 1'b0;
      flash_run_out <= 1'b0;
      serial_tx_line_out <= 1'b0;
      serial_tx_line_oe_out <= 1'b0;
      serial_rx_data_out <= 1'b1;
      can_tx_line_out <= 1'b0;
      can_tx_line_oe_out <= 1'b0;
      can_rx_data_out <= 1'b1;
      bus_power_sense_out <= 1'b0;
      pins_reserved_out <= 3'h0;
    end
    else
    begin
      boot_mode_out <= mode_out_d;
      boot_done_out <= done_d;
      flash_check_req_out <= chk_req_d;
      flash_run_out <= run_d;
      serial_tx_line_out <= stx_d;
      serial_tx_line_oe_out <= stx_oe_d;
      serial_rx_data_out <= srx_d;
      can_tx_line_out <= ctx_d;
      can_tx_line_oe_out <= ctx_oe_d;
      can_rx_data_out <= crx_d;
      bus_power_sense_out <= vbus_d;
      pins_reserved_out <= pins_d;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_decide;
    state_q == BMS_ST_WAIT && straps.valid;
  endsequence

  // Decision edge joined to the strap pattern with the sequence operator, not a boolean one
  chk_can_select: assert property (s_decide and (straps.strap_a && !straps.strap_b)
    |=> ##1 boot_mode_out == BMS_MODE_CAN && can_tx_line_oe_out)
    else $error("CAN mode not selected");
  chk_usb_select: assert property (s_decide and (!straps.strap_a && straps.strap_b)
    |=> ##1 boot_mode_out == BMS_MODE_USB)
    else $error("USB mode not selected");
  chk_uart_select: assert property (s_decide and (!straps.strap_a && !straps.strap_b)
    |=> ##1 boot_mode_out == BMS_MODE_UART && serial_tx_line_oe_out)
    else $error("serial port mode not selected");
  chk_flash_check: assert property (s_decide and (straps.strap_a && straps.strap_b)
    |=> ##1 flash_check_req_out && boot_mode_out == BMS_MODE_NONE)
    else $error("flash check not started");
  chk_flash_fallback: assert property (state_q == BMS_ST_CHECK && flash_check_done_in
    && !flash_valid_in |=> ##1 boot_mode_out == BMS_MODE_USB && !flash_run_out)
    else $error("invalid flash did not fall back to USB");
  chk_one_port: assert property (!(serial_tx_line_oe_out && can_tx_line_oe_out))
    else $error("two serial ports claimed at once");
  chk_claim_match: assert property (
    serial_tx_line_oe_out == (boot_mode_out == BMS_MODE_UART))
    else $error("serial pins claimed in wrong mode");
  chk_pin_budget: assert property (pins_reserved_out <= 3'(`BMS_MAX_ISP_PINS))
    else $error("too many pins reserved");
  chk_mode_hold: assert property (boot_done_out |=> boot_done_out && $stable(boot_mode_out))
    else $error("boot mode changed after decision");
  chk_vbus_share: assert property (bus_power_sense_out |-> boot_mode_out == BMS_MODE_USB
    && $past(boot_strap_b_in))
    else $error("bus power sense outside USB mode");

endmodule

`default_nettype wire

// ### test/bms_strap_host.sv
`timescale 1ns/1ps
`default_nettype none

// Board straps plus a programming host that answers the flash image check
module bms_strap_host
(
  input wire logic ref_clk_in,
  input wire logic strap_a_cfg_in,
  input wire logic strap_b_cfg_in,
  input wire logic [1:0] reply_cfg_in,
  input wire logic flash_check_req_in,
  output logic boot_strap_a_out,
  output logic boot_strap_b_out,
  output logic flash_check_done_out,
  output logic flash_valid_out
);
  logic [3:0] wait_q = 4'h0;
  logic tog_q = 1'b0;
  // Strap levels; strap b is also the host bus power level
  assign boot_strap_a_out = strap_a_cfg_in;
  assign boot_strap_b_out = strap_b_cfg_in;
  // Slow answer: three cycles after the request
  always_ff @(posedge ref_clk_in)
  begin
    wait_q <= flash_check_req_in ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
    tog_q <= ~tog_q;
  end
  // Reply 0 never answers, 1 valid image, 2 invalid image
  assign flash_check_done_out = (reply_cfg_in != 2'h0) && (wait_q >= 4'h3);
  // Valid is garbage while not qualified by done
  assign flash_valid_out = flash_check_done_out ? (reply_cfg_in == 2'h1) : tog_q;
endmodule

`default_nettype wire

// ### test/test_boot_mode_strap_selector.sv
`timescale 1ns/1ps
`default_nettype none

module test_boot_mode_strap_selector;
  import bms_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cfg_a = 1'b0;
  logic cfg_b = 1'b0;
  logic [1:0] cfg_reply = 2'h0;
  logic tx_d = 1'b0;
  logic rx_l = 1'b1;
  logic ctx_d = 1'b0;
  logic crx_l = 1'b1;
  logic st_a, st_b, f_done, f_valid, f_req, f_run, boot_done_out;
  logic s_tx, s_oe, s_rx, c_tx, c_oe, c_rx, vbus;
  logic [3:0] boot_mode_out;
  logic [2:0] pins;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  boot_mode_strap_selector #(.SETTLE_CYCLES(2), .FLASH_WAIT_CYCLES(8)) uut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .boot_strap_a_in(st_a),
    .boot_strap_b_in(st_b), .flash_check_done_in(f_done), .flash_valid_in(f_valid),
    .serial_tx_data_in(tx_d), .serial_rx_line_in(rx_l), .can_tx_data_in(ctx_d),
    .can_rx_line_in(crx_l), .boot_mode_out(boot_mode_out), .boot_done_out(boot_done_out),
    .flash_check_req_out(f_req), .flash_run_out(f_run), .serial_tx_line_out(s_tx),
    .serial_tx_line_oe_out(s_oe), .serial_rx_data_out(s_rx), .can_tx_line_out(c_tx),
    .can_tx_line_oe_out(c_oe), .can_rx_data_out(c_rx), .bus_power_sense_out(vbus),
    .pins_reserved_out(pins));

  bms_strap_host host (
    .ref_clk_in(ref_clk_in), .strap_a_cfg_in(cfg_a), .strap_b_cfg_in(cfg_b),
    .reply_cfg_in(cfg_reply), .flash_check_req_in(f_req), .boot_strap_a_out(st_a),
    .boot_strap_b_out(st_b), .flash_check_done_out(f_done), .flash_valid_out(f_valid));

  // Clock
  initial
  begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic conclude();
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Hang guard, far above the whole run
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic step(input int n);
    begin
      repeat (n) @(posedge ref_clk_in);
      #1;
    end
  endtask

  // Reset with given straps, then wait for the decision under a bound
  task automatic boot(input logic a, input logic b, input logic [1:0] r);
    int i;
    begin
      step(1);
      reset_in = 1'b1;
      cfg_a = a;
      cfg_b = b;
      cfg_reply = r;
      step(6);
      chk(boot_mode_out, 4'h0);
      chk({s_oe, c_oe, s_rx, c_rx}, 4'h3);
      reset_in = 1'b0;
      for (i = 0; i < 60 && boot_done_out !== 1'b1; i++)
        step(1);
      chk({3'h0, boot_done_out}, 4'h1);
    end
  endtask

  // Serial port mode; forwards serial lines, CAN stays free, straps ignored
  task automatic test_uart();
    begin
      boot(1'b0, 1'b0, 2'h0);
      chk(boot_mode_out, 4'h2);
      chk({1'h0, pins}, 4'h4);
      tx_d = 1'b1;
      rx_l = 1'b0;
      // CAN tx driven high too, so a leak onto the unclaimed line shows
      ctx_d = 1'b1;
      crx_l = 1'b0;
      cfg_a = 1'b1;
      step(3);
      chk({s_oe, s_tx, s_rx, c_oe}, 4'hc);
      chk({c_rx, c_tx, vbus, f_run}, 4'h8);
      chk(boot_mode_out, 4'h2);
      ctx_d = 1'b0;
      crx_l = 1'b1;
      rx_l = 1'b1;
    end
  endtask

  // CAN mode; forwards CAN lines, serial stays free
  task automatic test_can();
    begin
      boot(1'b1, 1'b0, 2'h0);
      chk(boot_mode_out, 4'h4);
      chk({1'h0, pins}, 4'h4);
      ctx_d = 1'b1;
      crx_l = 1'b0;
      rx_l = 1'b0;
      step(3);
      chk({c_oe, c_tx, c_rx, s_oe}, 4'hc);
      chk({s_rx, s_tx, vbus, f_req}, 4'h8);
      ctx_d = 1'b0;
      crx_l = 1'b1;
      rx_l = 1'b1;
    end
  endtask

  // USB mode; strap b pin carries bus power live, mode holds
  task automatic test_usb();
    begin
      boot(1'b0, 1'b1, 2'h0);
      chk(boot_mode_out, 4'h8);
      chk({1'h0, pins}, 4'h2);
      chk({s_oe, c_oe, vbus, f_run}, 4'h2);
      cfg_b = 1'b0;
      step(3);
      chk({3'h0, vbus}, 4'h0);
      chk(boot_mode_out, 4'h8);
    end
  endtask

  // Flash boot: valid image runs, invalid or silent check falls back to USB
  task automatic test_flash();
    begin
      boot(1'b1, 1'b1, 2'h1);
      chk(boot_mode_out, 4'h1);
      chk({f_run, f_req, s_oe, c_oe}, 4'h8);
      chk({1'h0, pins}, 4'h0);
      boot(1'b1, 1'b1, 2'h2);
      chk(boot_mode_out, 4'h8);
      chk({3'h0, f_run}, 4'h0);
      boot(1'b1, 1'b1, 2'h0);
      chk(boot_mode_out, 4'h8);
    end
  endtask

  // Main sequence
  initial
  begin
    test_uart();
    test_can();
    test_usb();
    test_flash();
    conclude();
  end
endmodule

`default_nettype wire
